// ===== hbsc_map.svh
/*
 * Holds: bit positions, reset values, sizes and timing figures of the
 * half-bridge serial control block.
 * Assumes: included by bare name from every design file that needs it.
 */
`ifndef HBSC_MAP_SVH
`define HBSC_MAP_SVH

// ---------------------------------------------------------------------
// frame geometry
// ---------------------------------------------------------------------
`define HBSC_WORD_W          16
`define HBSC_CNT_W           5
`define HBSC_FRAME_BITS      5'h10

// ---------------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------------
`define HBSC_C_CLR           0
`define HBSC_C_SW_LO         1
`define HBSC_C_SW_HI         6
`define HBSC_C_PWM_LO        7
`define HBSC_C_PWM_HI        12
`define HBSC_C_OLD_N         13
`define HBSC_C_OCS           14
`define HBSC_C_RUN           15
`define HBSC_CTRL_RESET      16'hE000

// ---------------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------------
`define HBSC_S_HEAT          0
`define HBSC_S_SW_LO         1
`define HBSC_S_SW_HI         6
`define HBSC_S_NU_LO         7
`define HBSC_S_NU_HI         12
`define HBSC_S_OVL           13
`define HBSC_S_STBY          14
`define HBSC_S_PSF           15

// ---------------------------------------------------------------------
// timing and queue depth
// ---------------------------------------------------------------------
`define HBSC_CLK_MHZ         50
`define HBSC_SCK_MAX_MHZ     2
`define HBSC_FIFO_DEPTH      8

`endif

// ===== hbsc_pkg.sv
/*
 * Holds: types shared by the half-bridge serial control files.
 * Assumes: nothing beyond the map header.
 */
package hbsc_pkg;
    typedef enum logic [1:0] {
        HBSC_IDLE,
        HBSC_SHIFT,
        HBSC_DONE
    } hbsc_state_t;
    typedef logic [15:0] hbsc_word_t;
endpackage

// ===== hbsc_fifo.sv
/*
 * Holds: a small flip-flop FIFO with valid/ready on both sides.
 * Assumes: one clock, asynchronous active-high reset, DEPTH a power of two.
 */
`timescale 1ns/1ps
`include "hbsc_map.svh"

module hbsc_fifo
    import hbsc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // ------------------------------------------------------------------
    // honest flags straight from the occupancy count
    // ------------------------------------------------------------------
    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    // storage and pointers; push and pop may share one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // data array is not reset: a word is only read once counted in
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

// ===== hbsc_top.sv
/*
 * Holds: serial control and status interface of a triple half-bridge
 * driver: frame sampling, control word, status word, driver gating.
 * Assumes: clk is 50 MHz; all serial pins and fault inputs come from
 * outside this domain and are synchronised here; the master runs a little
 * over the 2 MHz serial clock limit, but each serial clock phase spans 12 clk.
 */
// Functional notes
// - chip select fall starts a frame
// - input bit sampled on each falling clock
// - sixteen bits each way per frame
// - control word applied on chip select rise
// - reply line released while chip select high
// - reply bit changes only on rising clock
// - status word shifted out low bit first
// - early chip select rise aborts, nothing changes
// - clear bit resets supply and overload flags
// - bits 1..6 switch the six drivers on
// - bits 7..12 gate drivers with shared pwm
// - bit 13 low enables open load check
// - bit 14 high enables overcurrent cutoff
// - bit 15 low means standby, link works
// - status bit 0 shows heat warning
// - status 1..6 show on state or open load
// - overload flag set on driver shutdown
// - standby flag is inverse of run bit
// - supply fail flag set on undervoltage
// - control resets to bits 15..13 high
`timescale 1ns/1ps
`include "hbsc_map.svh"

module hbsc_top
    import hbsc_pkg::*;
#(
    parameter int FIFO_DEPTH = `HBSC_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in_line,
    output logic             serial_reply_line_o,
    output logic             serial_reply_line_oe,
    input  wire logic        pwm_in,
    input  wire logic        heat_warning,
    input  wire logic        undervoltage,
    input  wire logic [5:0]  short_trip,
    input  wire logic [5:0]  heat_trip,
    input  wire logic [5:0]  open_load,
    output logic [5:0]       driver_on,
    output logic             open_load_check_en,
    output logic             overcurrent_cut_en,
    output logic             standby
);
    // ------------------------------------------------------------------
    // input synchronisers: two flops, stage one read only by stage two
    // ------------------------------------------------------------------
    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic [2:0]  pin_d_r;
    logic [20:0] flt_s1_r;
    logic [20:0] flt_s2_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_r <= 3'h1;
            pin_s2_r <= 3'h1;
            pin_d_r  <= 3'h1;
        end else begin
            pin_s1_r <= {serial_in_line, serial_clk, chip_sel_n};
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flt_s1_r <= '0;
            flt_s2_r <= '0;
        end else begin
            flt_s1_r <= {pwm_in, heat_warning, undervoltage, short_trip, heat_trip, open_load};
            flt_s2_r <= flt_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // edge decode on the synchronised pins
    // ------------------------------------------------------------------
    wire        cs_n      = pin_s2_r[0];
    wire        cs_fall   = pin_d_r[0] && !pin_s2_r[0];
    wire        cs_rise   = !pin_d_r[0] && pin_s2_r[0];
    wire        sck_fall  = pin_d_r[1] && !pin_s2_r[1] && !cs_n;
    wire        sck_rise  = !pin_d_r[1] && pin_s2_r[1] && !cs_n;
    wire        din       = pin_s2_r[2];
    wire        pwm_s     = flt_s2_r[20];
    wire        heat_s    = flt_s2_r[19];
    wire        uv_s      = flt_s2_r[18];
    wire [5:0]  short_s   = flt_s2_r[17:12];
    wire [5:0]  hot_s     = flt_s2_r[11:6];
    wire [5:0]  open_s    = flt_s2_r[5:0];

    // ------------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------------
    hbsc_state_t                  state_r;
    logic [`HBSC_CNT_W-1:0]       bits_r;
    hbsc_word_t                   rx_r;
    hbsc_word_t                   tx_r;
    hbsc_word_t                   ctrl_r;
    logic                         do_r;
    logic                         oe_r;
    logic                         ovl_r;
    logic                         psf_r;
    logic [5:0]                   cut_r;
    logic [5:0]                   drv_r;
    logic                         ole_r;
    logic                         ocs_r;
    logic                         stby_r;
    logic                         fifo_in_ready;
    logic                         fifo_out_valid;
    hbsc_word_t                   fifo_out_data;

    // a full frame: sixteen or more falling clocks before chip select rose
    wire        frame_ok  = cs_rise && state_r == HBSC_SHIFT && bits_r == `HBSC_FRAME_BITS;
    wire [`HBSC_WORD_W-1:0] status_now;
    wire [5:0]  sw_on     = ctrl_r[`HBSC_C_SW_HI:`HBSC_C_SW_LO];
    wire [5:0]  pwm_sel   = ctrl_r[`HBSC_C_PWM_HI:`HBSC_C_PWM_LO];
    wire        run       = ctrl_r[`HBSC_C_RUN];
    wire        ole       = !ctrl_r[`HBSC_C_OLD_N];
    wire        ocs       = ctrl_r[`HBSC_C_OCS];
    wire [5:0]  trip      = (ocs ? short_s : 6'h00) | hot_s;
    wire [5:0]  live      = sw_on & ~cut_r & {6{run && !psf_r}};
    wire [5:0]  drv_nxt   = live & ~(pwm_sel & {6{!pwm_s}});
    wire [5:0]  stat_sw   = ole ? (open_s & ~sw_on) : drv_r;

    // status word assembled live; captured at frame start
    assign status_now[`HBSC_S_HEAT]                     = heat_s;
    assign status_now[`HBSC_S_SW_HI:`HBSC_S_SW_LO]      = stat_sw;
    assign status_now[`HBSC_S_NU_HI:`HBSC_S_NU_LO]      = 6'h00;
    assign status_now[`HBSC_S_OVL]                      = ovl_r;
    assign status_now[`HBSC_S_STBY]                     = !run;
    assign status_now[`HBSC_S_PSF]                      = psf_r;

    // ------------------------------------------------------------------
    // frame sequencer and shift registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= HBSC_IDLE;
            bits_r  <= '0;
            rx_r    <= '0;
            tx_r    <= '0;
        end else begin
            unique case (state_r)
                HBSC_IDLE: begin
                    if (cs_fall) begin
                        state_r <= HBSC_SHIFT;
                        bits_r  <= '0;
                        tx_r    <= status_now;
                    end
                end
                HBSC_SHIFT: begin
                    if (cs_rise) begin
                        state_r <= HBSC_DONE;
                    end else begin
                        if (sck_fall && bits_r != `HBSC_FRAME_BITS) begin
                            rx_r   <= {din, rx_r[`HBSC_WORD_W-1:1]};
                            bits_r <= bits_r + 1'b1;
                        end
                        if (sck_rise && bits_r != '0) begin
                            tx_r <= {1'b0, tx_r[`HBSC_WORD_W-1:1]};
                        end
                    end
                end
                HBSC_DONE: begin
                    state_r <= HBSC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // reply pin: released while deselected, bit 0 ready at the fall
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_r <= 1'b0;
            do_r <= 1'b0;
        end else begin
            oe_r <= !cs_n && !cs_rise;
            do_r <= (state_r == HBSC_SHIFT) ? tx_r[0] : status_now[0];
        end
    end

    // ------------------------------------------------------------------
    // control word: only a complete frame lands, at chip select rise
    // ------------------------------------------------------------------
    wire clr_now   = frame_ok && rx_r[`HBSC_C_CLR];
    // the queue drains only while deselected, one clk after the rise
    wire ctrl_load = fifo_out_valid && cs_n;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= `HBSC_CTRL_RESET;
        end else if (ctrl_load) begin
            ctrl_r <= fifo_out_data;
        end
    end

    // ------------------------------------------------------------------
    // sticky faults: a new fault beats the clear in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovl_r <= 1'b0;
            psf_r <= 1'b0;
            cut_r <= 6'h00;
        end else begin
            ovl_r <= (|(trip & sw_on)) || (ovl_r && !clr_now);
            psf_r <= uv_s || (psf_r && !clr_now);
            cut_r <= (trip & sw_on) | (clr_now ? 6'h00 : cut_r);
        end
    end

    // driver outputs registered so every port comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drv_r  <= 6'h00;
            ole_r  <= 1'b0;
            ocs_r  <= 1'b1;
            stby_r <= 1'b0;
        end else begin
            drv_r  <= drv_nxt;
            ole_r  <= ole;
            ocs_r  <= ocs;
            stby_r <= !run;
        end
    end

    // ------------------------------------------------------------------
    // accepted control words pass a short queue on their way to the
    // control register; it drains only while no frame is active
    // ------------------------------------------------------------------
    hbsc_fifo #(
        .WIDTH (`HBSC_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_log (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (frame_ok),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_r),
        .out_valid (fifo_out_valid),
        .out_ready (cs_n),
        .out_data  (fifo_out_data)
    );

    assign serial_reply_line_o  = do_r;
    assign serial_reply_line_oe = oe_r;
    assign driver_on            = drv_r;
    assign open_load_check_en   = ole_r;
    assign overcurrent_cut_en   = ocs_r;
    assign standby              = stby_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_short_frame;
        cs_rise && state_r == HBSC_SHIFT && bits_r != `HBSC_FRAME_BITS;
    endsequence

    property p_release;
        @(posedge clk) disable iff (sys_rst) cs_n && !cs_fall |=> !oe_r;
    endproperty
    a_release: assert property (p_release) else $error("reply driven while deselected");

    property p_drive;
        @(posedge clk) disable iff (sys_rst) cs_fall |=> oe_r;
    endproperty
    a_drive: assert property (p_drive) else $error("reply not driven after select");

    property p_abort;
        @(posedge clk) disable iff (sys_rst) s_short_frame |=> $stable(ctrl_r) ##1 $stable(ctrl_r);
    endproperty
    a_abort: assert property (p_abort) else $error("short frame changed control");

    property p_apply;
        @(posedge clk) disable iff (sys_rst) $changed(ctrl_r) |-> $past(cs_rise, 2);
    endproperty
    a_apply: assert property (p_apply) else $error("control changed mid frame");

    property p_clear;
        @(posedge clk) disable iff (sys_rst) clr_now && !uv_s |=> !psf_r;
    endproperty
    a_clear: assert property (p_clear) else $error("supply flag not cleared");

    property p_uv;
        @(posedge clk) disable iff (sys_rst) uv_s |=> psf_r;
    endproperty
    a_uv: assert property (p_uv) else $error("supply flag missed");

    property p_stby;
        @(posedge clk) disable iff (sys_rst) 1'b1 |=> stby_r == !$past(run);
    endproperty
    a_stby: assert property (p_stby) else $error("standby not inverse of run");

    property p_unused;
        @(posedge clk) disable iff (sys_rst) status_now[`HBSC_S_NU_HI:`HBSC_S_NU_LO] == 6'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits set");

    property p_bit_hold;
        @(posedge clk) disable iff (sys_rst) state_r == HBSC_SHIFT && !sck_rise && !cs_rise |=> $stable(tx_r);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("reply moved off rising clock");

    // a complete word must always find room, or it would be lost
    property p_fifo_room;
        @(posedge clk) disable iff (sys_rst) frame_ok |-> fifo_in_ready;
    endproperty
    a_fifo_room: assert property (p_fifo_room) else $error("control queue full at frame end");
endmodule

// ===== hbsc_master.sv
/*
 * Holds: behavioural serial master that drives frames into the block.
 * Assumes: clk is the block clock; the testbench calls frame().
 */
`timescale 1ns/1ps

module hbsc_master
    import hbsc_pkg::*;
(
    input  wire logic clk,
    output logic      chip_sel_n,
    output logic      serial_clk,
    output logic      serial_in_line,
    input  wire logic serial_reply
);
    // 12 clk per phase gives a link clock of about 2.08 MHz from a 50 MHz clk
    localparam int HALF = 12;

    // idle: deselected, clock low, data at its pull-down level
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        serial_in_line = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ---------------------------------------------------------------------
    // one frame; nbits 0 reads the first reply bit and aborts
    // ---------------------------------------------------------------------
    task automatic frame(input hbsc_word_t tx, input int nbits, output hbsc_word_t rx, output logic held);
        rx = '0;
        held = 1'b1;
        step(1);
        chip_sel_n = 1'b0;
        step(10);
        rx[0] = serial_reply;                         // bit 0 readable before any clock
        for (int i = 0; i < nbits; i++) begin
            if (serial_reply !== rx[(i > 0) ? i - 1 : 0]) begin
                held = 1'b0;                          // reply moved before a rising edge
            end
            serial_clk = 1'b1;
            serial_in_line = tx[i];                   // low bit first, steady over the fall
            step(HALF);
            rx[i] = serial_reply;
            serial_clk = 1'b0;
            step(HALF);
        end
        serial_in_line = 1'b0;
        chip_sel_n = 1'b1;                            // sixteen clocks make a word
        step(8);
    endtask
endmodule

// ===== tb_half_bridge_serial_control.sv
/*
 * Holds: self-checking testbench of the half-bridge serial control block.
 * Assumes: hbsc_master in its own file; words sent avoid test patterns.
 */
`timescale 1ns/1ps

module tb_half_bridge_serial_control
    import hbsc_pkg::*;
;
    logic       clk;
    logic       sys_rst;
    logic       pwm_in;
    logic       heat_warning;
    logic       undervoltage;
    logic [5:0] short_trip;
    logic [5:0] heat_trip;
    logic [5:0] open_load;
    wire        chip_sel_n;
    wire        serial_clk;
    wire        serial_in_line;
    wire        serial_reply_line_o;
    wire        serial_reply_line_oe;
    wire  [5:0] driver_on;
    wire        open_load_check_en;
    wire        overcurrent_cut_en;
    wire        standby;
    wire        serial_reply;
    int         n_errors;
    int         n_checks;
    hbsc_word_t rx;
    logic       held;
    wire  [3:0] mode_pins;

    // reply pin resolved from the drive enable; released means floating
    assign serial_reply = serial_reply_line_oe ? serial_reply_line_o : 1'bz;
    // mode pins and reply enable gathered for one compare
    assign mode_pins = {overcurrent_cut_en, open_load_check_en, standby, serial_reply_line_oe};

    hbsc_top uut (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .chip_sel_n           (chip_sel_n),
        .serial_clk           (serial_clk),
        .serial_in_line       (serial_in_line),
        .serial_reply_line_o  (serial_reply_line_o),
        .serial_reply_line_oe (serial_reply_line_oe),
        .pwm_in               (pwm_in),
        .heat_warning         (heat_warning),
        .undervoltage         (undervoltage),
        .short_trip           (short_trip),
        .heat_trip            (heat_trip),
        .open_load            (open_load),
        .driver_on            (driver_on),
        .open_load_check_en   (open_load_check_en),
        .overcurrent_cut_en   (overcurrent_cut_en),
        .standby              (standby)
    );

    hbsc_master mst (
        .clk            (clk),
        .chip_sel_n     (chip_sel_n),
        .serial_clk     (serial_clk),
        .serial_in_line (serial_in_line),
        .serial_reply   (serial_reply)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ---------------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input hbsc_word_t seen, input hbsc_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drv(input logic [5:0] exp);
        check({10'h000, driver_on}, {10'h000, exp});
    endtask

    // full frame: reply word, bit hold and release after deselect
    task automatic xfer(input hbsc_word_t tx, input hbsc_word_t exp);
        mst.frame(tx, 16, rx, held);
        check(rx, exp);
        check({15'h0000, held}, 16'h0001);
        check({15'h0000, serial_reply_line_oe}, 16'h0000);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog: about 30 frames of 410 clk need under 0.3 ms
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end

    // ---------------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------------
    initial begin
        n_errors = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        pwm_in = 1'b1;
        heat_warning = 1'b0;
        undervoltage = 1'b0;
        short_trip = 6'h00;
        heat_trip = 6'h00;
        open_load = 6'h00;
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(5);
        check({12'h000, mode_pins}, 16'h0008);
        drv(6'h00);
        heat_warning = 1'b1;
        step(4);
        xfer(16'hE000, 16'h0001);
        heat_warning = 1'b0;
        $display("test reset_and_heat done");
        // each driver alone; the next frame reports the previous word
        for (int i = 0; i <= 6; i++) begin
            xfer((i < 6) ? (16'hE000 | (16'h0002 << i)) : 16'hE000, (i == 0) ? 16'h0000 : (16'h0001 << i));
            if (i < 6) begin
                drv(6'h01 << i);
            end
        end
        $display("test switches done");
        // one gate bit at a time, pwm low only between frames; switch
        // bits stay set so no word is a test pattern
        for (int j = 0; j < 6; j++) begin
            xfer(16'hE07E | (16'h0080 << j), (j == 0) ? 16'h0000 : 16'h007E);
            pwm_in = 1'b0;
            step(6);
            drv(6'h3F & ~(6'h01 << j));
            pwm_in = 1'b1;
            step(6);
        end
        $display("test pwm_gating done");
        open_load = 6'h15;
        xfer(16'hC000, 16'h007E);
        check({12'h000, mode_pins}, 16'h000C);
        xfer(16'h2000, 16'h002A);
        check({12'h000, mode_pins}, 16'h0002);
        xfer(16'hE000, 16'h4000);
        open_load = 6'h00;
        $display("test modes done");
        undervoltage = 1'b1;
        step(6);
        undervoltage = 1'b0;
        step(6);
        xfer(16'hE000, 16'h8000);
        xfer(16'hE001, 16'h8000);
        xfer(16'hE002, 16'h0000);
        heat_trip = 6'h01;
        step(6);
        heat_trip = 6'h00;
        step(6);
        drv(6'h00);
        xfer(16'hE002, 16'h2000);
        xfer(16'hE003, 16'h2000);
        drv(6'h01);
        xfer(16'hA008, 16'h0002);
        short_trip = 6'h04;
        step(6);
        drv(6'h04);
        xfer(16'hE008, 16'h0008);
        drv(6'h00);
        short_trip = 6'h00;
        step(6);
        xfer(16'hE009, 16'h2000);
        drv(6'h04);
        $display("test faults done");
        heat_warning = 1'b1;
        step(4);
        mst.frame(16'h0000, 0, rx, held);
        check(rx, 16'h0001);
        mst.frame(16'h0000, 5, rx, held);
        check(rx, 16'h0009);
        drv(6'h04);
        check({15'h0000, standby}, 16'h0000);
        xfer(16'hE000, 16'h0009);
        $display("test abort_and_short done");
        complete_run();
    end
endmodule
